// *** verilog/test_access_control_regs.sv ***
/*
  Test-space control and status bank: nonvolatile bank select, reload and
  programming arm with its timeout, memory owner select, core hold reset,
  and sticky single-wire error flags, all reached over APB.
  Assumes error detectors on the single-wire link deliver one-cycle pulses
  synchronous to pclk, and that the APB master keeps to the protocol.
*/
`timescale 1ns/1ps
`include "tac_defs.svh"

module test_access_control_regs
  import tac_pkg::*;
#(
  parameter int PROG_TIMEOUT_CYCLES = `PROG_TIMEOUT_CYC
)
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  // Single-wire receiver error events
  input wire swi_err_evt_t swi_err_evt,
  // Nonvolatile memory control
  output logic [2:0] nv_bank_sel,
  output logic nv_program_start,
  output logic nv_program_active,
  output logic nv_cache_reload,
  // Memory ownership and core control
  output logic core_mem_access,
  output logic iface_mem_access,
  output logic core_hold_reset,
  // Interrupt
  output logic irq
);

  // ----------------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------------

  // One-hot select of the six registers; all zero means unmapped.
  function automatic logic [5:0] reg_decode(input logic [7:0] addr);
    logic [5:0] sel;
    sel = 6'h00;
    unique case (addr[7:2])
      `IDX_NV_BANK_ACCESS: sel = 6'h01;
      `IDX_MEM_OWNER: sel = 6'h02;
      `IDX_SWI_ERR_A: sel = 6'h04;
      `IDX_SWI_ERR_B: sel = 6'h08;
      `IDX_IRQ_STATUS: sel = 6'h10;
      `IDX_IRQ_MASK: sel = 6'h20;
      default: sel = 6'h00;
    endcase
    return sel;
  endfunction

  // ----------------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------------
  localparam logic [17:0] TIMEOUT_LAST = 18'(PROG_TIMEOUT_CYCLES - 1);

  nv_bank_access_t bank_q;
  logic [7:0] owner_q;
  logic [7:0] err_a_q;
  logic [1:0] err_b_q;
  logic [2:0] irq_status_q;
  logic [2:0] irq_mask_q;
  logic [17:0] timer_q;
  prog_state_t prog_state_q;
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;
  logic irq_q;
  logic start_q;
  logic reload_q;
  logic core_acc_q;

  logic setup_phase;
  logic wr_commit;
  logic [5:0] sel_setup;
  logic [5:0] wr_sel;
  nv_bank_access_t wr_bank;
  logic prog_set;
  logic prog_clear_sw;
  logic timer_expire;
  logic auto_clear;
  logic [2:0] irq_event;

  assign setup_phase = psel && !penable;
  // A write lands only at the edge where the access phase meets pready.
  assign wr_commit = psel && penable && pwrite && pready_q;
  assign sel_setup = reg_decode(paddr);
  assign wr_sel = wr_commit ? sel_setup : 6'h00;
  assign wr_bank = nv_bank_access_t'(pwdata[7:0]);

  // ----------------------------------------------------------------------
  // APB answer
  // ----------------------------------------------------------------------

  // The answer is prepared in the setup cycle so the access phase
  // completes in its first cycle with no wait states.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end
    else
    begin
      pready_q <= setup_phase;
      pslverr_q <= setup_phase && (sel_setup == 6'h00);
    end
  end

  // Read data is sampled in every setup cycle, so an unmapped access of
  // either direction answers zero; reserved bits read as zero.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata_q <= 32'h0000_0000;
    else if (setup_phase)
    begin
      unique case (sel_setup)
        6'h01: prdata_q <= {24'h00_0000, 2'h0, bank_q[5:0]};
        6'h02: prdata_q <= {24'h00_0000, 6'h00, owner_q[1:0]};
        6'h04: prdata_q <= {24'h00_0000, err_a_q};
        6'h08: prdata_q <= {30'h0000_0000, err_b_q};
        6'h10: prdata_q <= {29'h0000_0000, irq_status_q};
        6'h20: prdata_q <= {29'h0000_0000, irq_mask_q};
        default: prdata_q <= 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Nonvolatile bank access control
  // ----------------------------------------------------------------------

  // rising arm detect
  // A re-arm meeting the automatic clear restarts the timer, else the flag would stay untimed.
  assign prog_set = wr_sel[0] && wr_bank.iface_nv_program && (!bank_q.iface_nv_program || auto_clear);
  assign prog_clear_sw = wr_sel[0] && !wr_bank.iface_nv_program;
  assign auto_clear = (prog_state_q == PROG_EXPIRED) && !bank_q.program_timeout_ignore;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      bank_q <= nv_bank_access_t'(`RST_NV_BANK_ACCESS);
    else
    begin
      if (wr_sel[0])
      begin
        if (wr_bank.nv_bank_select <= `BANK_LAST_CODE)
          bank_q.nv_bank_select <= wr_bank.nv_bank_select;
        bank_q.program_timeout_ignore <= wr_bank.program_timeout_ignore;
        bank_q.iface_nv_program <= wr_bank.iface_nv_program;
      end
      else if (auto_clear)
      begin
        bank_q.iface_nv_program <= 1'b0;
      end
      // The reload bit is a strobe and never holds a one.
      bank_q.nv_cache_reload <= 1'b0;
      bank_q.rsvd <= 2'h0;
    end
  end

  // ----------------------------------------------------------------------
  // Programming timer
  // ----------------------------------------------------------------------

  // The timer runs only while the arm flag is set. When it ends with the
  // ignore bit high the flag stays; clearing the ignore bit later then
  // ends programming at once, since the time has already run out.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prog_state_q <= PROG_IDLE;
      timer_q <= 18'h0_0000;
    end
    else if (prog_set)
    begin
      prog_state_q <= PROG_ARMED;
      timer_q <= 18'h0_0000;
    end
    else if (prog_clear_sw || auto_clear)
    begin
      prog_state_q <= PROG_IDLE;
      timer_q <= 18'h0_0000;
    end
    else
    begin
      unique case (prog_state_q)
        PROG_IDLE: timer_q <= 18'h0_0000;
        PROG_ARMED:
        begin
          if (timer_expire)
            prog_state_q <= PROG_EXPIRED;
          else
            timer_q <= timer_q + 18'h0_0001;
        end
        PROG_EXPIRED: prog_state_q <= PROG_EXPIRED;
        default: prog_state_q <= PROG_IDLE;
      endcase
    end
  end

  assign timer_expire = (timer_q == TIMEOUT_LAST);

  // ----------------------------------------------------------------------
  // Memory owner and core control
  // ----------------------------------------------------------------------

  // Only the two defined bits are kept; the rest read as zero.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      owner_q <= `RST_MEM_OWNER;
      core_acc_q <= `RST_CORE_ACCESS;
    end
    else if (wr_sel[1])
    begin
      owner_q <= {6'h00, pwdata[1:0]};
      // The core's grant is kept in its own flop so that the output needs no inverter.
      core_acc_q <= !pwdata[`OWNER_IFACE_BIT];
    end
  end

  // ----------------------------------------------------------------------
  // Single-wire error flags
  // ----------------------------------------------------------------------

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++)
    begin : g_err_a
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          err_a_q[gi] <= 1'b0;
        else if (swi_err_evt.a[gi])
          err_a_q[gi] <= 1'b1;
        else if (wr_sel[2])
          err_a_q[gi] <= pwdata[gi];
      end
    end
    for (gi = 0; gi < 2; gi++)
    begin : g_err_b
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          err_b_q[gi] <= 1'b0;
        else if (swi_err_evt.b[gi])
          err_b_q[gi] <= 1'b1;
        else if (wr_sel[3])
          err_b_q[gi] <= pwdata[gi];
      end
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Interrupt status and mask
  // ----------------------------------------------------------------------

  assign irq_event[`IRQ_ERR_A_BIT] = |swi_err_evt.a;
  assign irq_event[`IRQ_ERR_B_BIT] = |swi_err_evt.b;
  assign irq_event[`IRQ_TIMEOUT_BIT] = auto_clear;

  // Write one clears; a new event in the same cycle keeps its bit set.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_status_q <= `RST_IRQ;
    else
      irq_status_q <= (irq_status_q & ~(wr_sel[4] ? pwdata[2:0] : 3'h0)) | irq_event;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_mask_q <= `RST_IRQ;
    else if (wr_sel[5])
      irq_mask_q <= pwdata[2:0];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_q <= 1'b0;
    else
      irq_q <= |(irq_status_q & irq_mask_q);
  end

  // ----------------------------------------------------------------------
  // Control outputs
  // ----------------------------------------------------------------------

  // Strobes last one cycle after the committing write edge.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      start_q <= 1'b0;
      reload_q <= 1'b0;
    end
    else
    begin
      start_q <= prog_set;
      reload_q <= wr_sel[0] && wr_bank.nv_cache_reload;
    end
  end

  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign prdata = prdata_q;
  assign irq = irq_q;
  assign nv_bank_sel = bank_q.nv_bank_select;
  assign nv_program_active = bank_q.iface_nv_program;
  assign nv_program_start = start_q;
  // reload uses bank as updated by the same write
  assign nv_cache_reload = reload_q;
  assign core_mem_access = core_acc_q;
  assign iface_mem_access = owner_q[`OWNER_IFACE_BIT];
  assign core_hold_reset = owner_q[`OWNER_HOLD_BIT];

endmodule // test_access_control_regs

// *** verilog/tac_defs.svh ***
/*
  Register offsets, field positions, reset values and timing counts of the
  test-access control bank. Assumes a 10 MHz register clock and 32-bit APB.
*/
`ifndef TAC_DEFS_SVH
`define TAC_DEFS_SVH

// ----------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define IDX_NV_BANK_ACCESS 6'h0D
`define IDX_MEM_OWNER 6'h0E
`define IDX_SWI_ERR_A 6'h14
`define IDX_SWI_ERR_B 6'h15
`define IDX_IRQ_STATUS 6'h20
`define IDX_IRQ_MASK 6'h21

// ----------------------------------------------------------------------
// Field positions and codes
// ----------------------------------------------------------------------
`define BANK_LAST_CODE 3'h5
`define OWNER_IFACE_BIT 0
`define OWNER_HOLD_BIT 1
`define IRQ_ERR_A_BIT 0
`define IRQ_ERR_B_BIT 1
`define IRQ_TIMEOUT_BIT 2

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define RST_NV_BANK_ACCESS 8'h00
`define RST_MEM_OWNER 8'h00
`define RST_CORE_ACCESS 1'b1
`define RST_SWI_ERR_A 8'h00
`define RST_SWI_ERR_B 2'h0
`define RST_IRQ 3'h0

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define CLK_FREQ_KHZ 10000
`define PROG_TIMEOUT_MS 15
`define PROG_TIMEOUT_CYC (`PROG_TIMEOUT_MS * `CLK_FREQ_KHZ)

`endif

// *** verilog/tac_pkg.sv ***
/*
  Types shared by the test-access control bank: register layouts, event
  carriers and the programming-timer states. Assumes tac_defs.svh alongside.
*/
package tac_pkg;

  // Layout of the nonvolatile bank access control register.
  typedef struct packed {
    logic [1:0] rsvd;
    logic nv_cache_reload;
    logic program_timeout_ignore;
    logic iface_nv_program;
    logic [2:0] nv_bank_select;
  } nv_bank_access_t;

  // Error events from the single-wire interface receiver, one-cycle pulses.
  typedef struct packed {
    logic [1:0] b;
    logic [7:0] a;
  } swi_err_evt_t;

  // Programming timer states.
  typedef enum logic [2:0] {
    PROG_IDLE = 3'b001,
    PROG_ARMED = 3'b010,
    PROG_EXPIRED = 3'b100
  } prog_state_t;

endpackage

// *** dv/test_access_control_regs_chk.sv ***
/*
  Port assertions for the test-access bank.
  Assumes a protocol-keeping APB master and the bind at the foot.
*/
`timescale 1ns/1ps
`include "tac_defs.svh"
module test_access_control_regs_chk
  import tac_pkg::*;
#(
  parameter int PROG_TIMEOUT_CYCLES = 20
)
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  // Events and controls
  input wire swi_err_evt_t swi_err_evt,
  input wire logic [2:0] nv_bank_sel,
  input wire logic nv_program_start,
  input wire logic nv_program_active,
  input wire logic nv_cache_reload,
  input wire logic core_mem_access,
  input wire logic iface_mem_access,
  input wire logic core_hold_reset,
  input wire logic irq
);
  logic wr_done;
  logic wr_bank;
  logic wr_own;
  logic ign_q;
  logic [19:0] act_cnt_q;

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Completed writes, as the register sees them.
  assign wr_done = psel && penable && pready && pwrite;
  assign wr_bank = wr_done && (paddr[7:2] == `IDX_NV_BANK_ACCESS);
  assign wr_own = wr_done && (paddr[7:2] == `IDX_MEM_OWNER);

  // Mirror of the ignore bit and age of the program flag; any bank write restarts the age, which only loosens it.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ign_q <= 1'b0;
      act_cnt_q <= '0;
    end
    else
    begin
      if (wr_bank)
        ign_q <= pwdata[4];
      act_cnt_q <= (!nv_program_active || wr_bank) ? '0 : act_cnt_q + 20'h1;
    end
  end

  AST_READY_FIRST: assert property (psel && !penable |=> pready) else $error("no ready in access cycle");
  AST_READY_ONE: assert property (pready |=> !pready) else $error("ready held too long");
  AST_UNMAPPED: assert property (psel && !penable && !(paddr[7:2] inside {6'h0D, 6'h0E, 6'h14, 6'h15, 6'h20, 6'h21})
    |=> pslverr && prdata == 32'h0) else $error("unmapped access not refused");
  AST_BANK_SEL: assert property (wr_bank && pwdata[2:0] <= 3'h5 |=> nv_bank_sel == $past(pwdata[2:0]))
    else $error("bank select not taken");
  AST_START: assert property ($rose(nv_program_active) |-> nv_program_start)
    else $error("no program start pulse");
  AST_TIMEOUT: assert property (!ign_q |-> act_cnt_q <= PROG_TIMEOUT_CYCLES + 6)
    else $error("program flag outlived timeout");
  AST_RELOAD: assert property (wr_bank && pwdata[5] |-> ##[1:2] nv_cache_reload)
    else $error("no reload pulse");
  AST_OWNER: assert property (wr_own |=> iface_mem_access == $past(pwdata[0]) && core_mem_access != iface_mem_access)
    else $error("owner select wrong");
  AST_HOLD: assert property (wr_own |=> core_hold_reset == $past(pwdata[1]))
    else $error("core hold wrong");
endmodule // test_access_control_regs_chk

bind test_access_control_regs test_access_control_regs_chk #(.PROG_TIMEOUT_CYCLES(PROG_TIMEOUT_CYCLES)) u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr), .swi_err_evt(swi_err_evt),
  .nv_bank_sel(nv_bank_sel), .nv_program_start(nv_program_start), .nv_program_active(nv_program_active),
  .nv_cache_reload(nv_cache_reload), .core_mem_access(core_mem_access), .iface_mem_access(iface_mem_access),
  .core_hold_reset(core_hold_reset), .irq(irq));

// *** dv/swi_err_model.sv ***
/*
  Model of the single-wire link error detectors feeding the bank.
  Assumes the bench asks for one error at a time.
*/
`timescale 1ns/1ps
module swi_err_model
  import tac_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Request: which of the ten errors to raise
  input wire logic req,
  input wire logic [3:0] idx,
  // Event pulses
  output swi_err_evt_t evt
);
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      evt <= '0;
    else
      evt <= req ? swi_err_evt_t'(10'h1 << idx) : '0;
endmodule // swi_err_model

// *** dv/test_access_control_regs_tb_top.sv ***
/*
  Self-checking bench for the test-access bank.
  Assumes a short program timeout parameter of 20 cycles.
*/
`timescale 1ns/1ps
module test_access_control_regs_tb_top;
  import tac_pkg::*;
  localparam int T = 20;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, req, er;
  logic start, active, reload, core_acc, if_acc, hold, irq;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd, exp_a;
  logic [3:0] idx;
  logic [2:0] bank;
  swi_err_evt_t evt;
  int n_errors, n_compared, n_start, n_reload, n;

  test_access_control_regs #(.PROG_TIMEOUT_CYCLES(T)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .swi_err_evt(evt), .nv_bank_sel(bank), .nv_program_start(start),
    .nv_program_active(active), .nv_cache_reload(reload), .core_mem_access(core_acc),
    .iface_mem_access(if_acc), .core_hold_reset(hold), .irq(irq));
  swi_err_model u_swi (.pclk(pclk), .presetn(presetn), .req(req), .idx(idx), .evt(evt));

  // 10 MHz clock.
  initial
  begin
    pclk = 0;
    forever #50 pclk = ~pclk;
  end

  // Pulses are counted so that a missing or doubled one shows.
  always @(posedge pclk)
  begin
    if (start === 1'b1) n_start++;
    if (reload === 1'b1) n_reload++;
  end

  // ----------------------------------------
  // Bus and check tasks
  // ----------------------------------------
  task give_verdict;
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task tick(input int k);
    repeat (k) @(posedge pclk);
    #1;
  endtask

  // One APB transfer; the wait for ready is bounded.
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int c;
    @(posedge pclk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    c = 0;
    do
    begin
      @(posedge pclk);
      c++;
    end while (pready !== 1'b1 && c < 16);
    if (pready !== 1'b1)
    begin
      n_errors++;
      give_verdict;
    end
    rd = prdata; er = pslverr;
    psel <= 0; penable <= 0;
  endtask

  task rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
    apb(0, a, 0);
    chk(nm, rd, e);
  endtask

  initial
  begin
    psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0; req = 0; idx = 0; presetn = 0;
    n_errors = 0; n_compared = 0; n_start = 0; n_reload = 0;
    repeat (4) @(posedge pclk);
    presetn <= 1;
    tick(1);
    chk("core_rst", core_acc, 1);
    rdc("bank_rst", 8'h34, 0);
    rdc("owner_rst", 8'h38, 0);
    rdc("err_rst", 8'h50, 0);
    // Every bank code, then a code past the last one.
    for (int i = 0; i < 6; i++)
    begin
      apb(1, 8'h34, i);
      tick(1);
      chk("bank_sel", bank, i);
      rdc("bank_rd", 8'h34, i);
    end
    apb(1, 8'h34, 32'h6);
    rdc("bank_keep", 8'h34, 5);
    apb(1, 8'h34, 32'h25);
    tick(2);
    chk("reload", n_reload, 1);
    rdc("reload_rd", 8'h34, 5);
    apb(1, 8'h34, 32'h5);
    tick(2);
    chk("reload_none", n_reload, 1);
    apb(1, 8'h38, 1);
    tick(1);
    chk("iface", {if_acc, core_acc}, 2'b10);
    apb(1, 8'h38, 2);
    tick(1);
    chk("hold", {hold, core_acc}, 2'b11);
    apb(1, 8'h38, 0);
    tick(1);
    chk("core", {hold, if_acc, core_acc}, 3'b001);
    // Arm, let the timer run out, then arm with the timeout ignored.
    apb(1, 8'h34, 32'h8);
    tick(T - 2);
    chk("start", n_start, 1);
    chk("armed", active, 1);
    n = 0;
    while (active !== 1'b0 && n < 10)
    begin
      tick(1);
      n++;
    end
    chk("expired", active, 0);
    rdc("irq_tmo", 8'h80, 4);
    apb(1, 8'h80, 7);
    apb(1, 8'h34, 32'h18);
    tick(T + 6);
    chk("ignored", active, 1);
    chk("start2", n_start, 2);
    apb(1, 8'h34, 0);
    tick(1);
    chk("disarm", active, 0);
    // Each link error in turn; earlier flags must stay.
    exp_a = 0;
    for (int i = 0; i < 10; i++)
    begin
      @(posedge pclk);
      req <= 1;
      idx <= 4'(i);
      @(posedge pclk);
      req <= 0;
      exp_a[i] = 1;
      tick(2);
      rdc("err_a", 8'h50, exp_a[7:0]);
      rdc("err_b", 8'h54, exp_a[9:8]);
    end
    chk("irq_masked", irq, 0);
    rdc("irq_st", 8'h80, 3);
    apb(1, 8'h84, 1);
    tick(2);
    chk("irq_on", irq, 1);
    apb(1, 8'h80, 7);
    tick(2);
    chk("irq_off", irq, 0);
    apb(1, 8'h50, 0);
    rdc("err_clr", 8'h50, 0);
    apb(0, 8'h40, 0);
    chk("unm_err", er, 1);
    chk("unm_rd", rd, 0);
    give_verdict;
  end
endmodule // test_access_control_regs_tb_top
